// ==== core/bus_status_pkg.sv ====
// constants shared by the backplane status output logic.
// assumes one 125 MHz clock; all core-side inputs are on that clock.
// ****************************************
// How it works
// - the wait output is high while the processor waits on ready low or halt.
// - the interrupt-enable output mirrors the enable flip-flop, which lets requests in.
// - clearing that flip-flop drops the output and blocks every request until set again.
// - opcode-fetch status is high only in the cycle that fetches an instruction's first byte.
// - output-cycle status is high in output cycles, with the port address on the bus.
// - output data is valid on the data lines for the whole write strobe.
// ****************************************
package bus_status_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // write strobe width in ns, rounded down to whole cycles
  localparam int unsigned WR_STROBE_NS = 480;
  localparam int unsigned WR_STROBE_CYC =
    (WR_STROBE_NS / CLK_PERIOD_NS) < 1 ? 1 : WR_STROBE_NS / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CNT_ZERO = 8'h00;
endpackage

// ==== core/pin_sync.sv ====
// two-flop synchroniser for backplane pins.
// assumes the pins are asynchronous to i_clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // first stage is read by the second stage only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_pin;
      o_sync <= meta_q;
    end
  end
endmodule // pin_sync

// ==== core/cpu_bus_status_outputs.sv ====
// backplane status and command/control outputs of the processor board.
// assumes core-side strobes are one-cycle pulses on i_clk; ready and
// interrupt request arrive from backplane pins.
`timescale 1ns/1ps
module cpu_bus_status_outputs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cycle_start,
  input wire logic i_fetch_first,
  input wire logic i_out_cycle,
  input wire logic [7:0] i_port_addr,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_out_data,
  input wire logic i_halt_exec,
  input wire logic i_ei_exec,
  input wire logic i_di_exec,
  input wire logic i_ready,
  input wire logic i_int_req,
  output logic o_wait_state_out,
  output logic o_int_enabled_out,
  output logic o_int_accept,
  output logic o_opcode_fetch_status,
  output logic o_output_cycle_status,
  output logic [15:0] o_addr,
  output logic [7:0] o_bidir_data_lines_o,
  output logic o_bidir_data_lines_oe,
  output logic o_write_strobe
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] pins_s;

  pin_sync #(.WIDTH(2)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin({i_int_req, i_ready}),
    .o_sync(pins_s)
  );

  logic ready_s;
  logic irq_s;
  assign ready_s = pins_s[0];
  assign irq_s = pins_s[1];

  // ****************************************
  // interrupt enable flip-flop
  // ****************************************
  logic halted_q;
  logic accept_now;
  // a request is taken only at a cycle boundary so it never splits a cycle
  assign accept_now = o_int_enabled_out & irq_s & i_cycle_start;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_int_enabled_out <= 1'b0;
    end else if (i_di_exec) begin
      o_int_enabled_out <= 1'b0;
    end else if (i_ei_exec) begin
      o_int_enabled_out <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_int_accept <= 1'b0;
    end else begin
      o_int_accept <= accept_now;
    end
  end

  // ****************************************
  // wait state
  // ****************************************
  // halt is left only by an accepted interrupt or reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halted_q <= 1'b0;
    end else if (i_halt_exec) begin
      halted_q <= 1'b1;
    end else if (accept_now) begin
      halted_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wait_state_out <= 1'b0;
    end else begin
      o_wait_state_out <= ~ready_s | halted_q | i_halt_exec;
    end
  end

  // ****************************************
  // per-cycle status latch
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_opcode_fetch_status <= 1'b0;
      o_output_cycle_status <= 1'b0;
      o_addr <= bus_status_pkg::ADDR_RESET;
    end else if (i_cycle_start) begin
      o_opcode_fetch_status <= i_fetch_first;
      o_output_cycle_status <= i_out_cycle;
      // port address shows on both address bytes in an output cycle
      o_addr <= i_out_cycle ? {i_port_addr, i_port_addr} : i_mem_addr;
    end
  end

  // ****************************************
  // write strobe and data out
  // ****************************************
  logic [7:0] wr_cnt_q;
  logic wr_done_q;

  // strobe waits until ready so a slow port still sees full width
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_cnt_q <= bus_status_pkg::CNT_ZERO;
      wr_done_q <= 1'b0;
      o_write_strobe <= 1'b0;
    end else if (i_cycle_start) begin
      wr_cnt_q <= bus_status_pkg::CNT_ZERO;
      wr_done_q <= 1'b0;
      o_write_strobe <= 1'b0;
    end else if (o_write_strobe) begin
      if (wr_cnt_q == 8'(bus_status_pkg::WR_STROBE_CYC - 1)) begin
        o_write_strobe <= 1'b0;
        wr_done_q <= 1'b1;
      end else begin
        wr_cnt_q <= wr_cnt_q + 8'h01;
      end
    end else if (o_output_cycle_status & ~wr_done_q & ready_s) begin
      o_write_strobe <= 1'b1;
      wr_cnt_q <= bus_status_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bidir_data_lines_o <= bus_status_pkg::DATA_RESET;
      o_bidir_data_lines_oe <= 1'b0;
    end else if (i_cycle_start) begin
      o_bidir_data_lines_o <= i_out_data;
      o_bidir_data_lines_oe <= i_out_cycle;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // counts strobe cycles so the width check needs no long repetition
  logic [7:0] hi_len_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_len_q <= bus_status_pkg::CNT_ZERO;
    end else if (o_write_strobe) begin
      hi_len_q <= hi_len_q + 8'h01;
    end else begin
      hi_len_q <= bus_status_pkg::CNT_ZERO;
    end
  end

  sequence s_strobe_rise;
    !o_write_strobe ##1 o_write_strobe;
  endsequence

  sequence s_strobe_fall;
    o_write_strobe ##1 !o_write_strobe;
  endsequence

  a_ie_set_mirror: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ei_exec && !i_di_exec |=> o_int_enabled_out)
    else $error("enable did not set interrupt flag");
  a_accept_taken: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_int_enabled_out && irq_s && i_cycle_start |=> o_int_accept)
    else $error("enabled request not accepted");
  a_ie_clear_block: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_di_exec |=> !o_int_enabled_out ##1 !o_int_accept)
    else $error("interrupt accepted after disable");
  a_accept_gated: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_int_accept |-> $past(o_int_enabled_out))
    else $error("accept while disabled");

  // a halt with interrupts already on may be left at once, so it is excluded
  a_wait_on_halt: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_halt_exec && !o_int_enabled_out && !i_ei_exec
      |=> o_wait_state_out [*3])
    else $error("halt did not hold wait");
  a_wait_on_ready: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !ready_s |=> o_wait_state_out)
    else $error("ready low without wait");

  a_fetch_status: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_cycle_start |=> o_opcode_fetch_status == $past(i_fetch_first))
    else $error("fetch status wrong");
  a_out_status: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_cycle_start |=> o_output_cycle_status == $past(i_out_cycle))
    else $error("output status wrong");
  a_status_stable: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !$past(i_cycle_start) |-> $stable(o_output_cycle_status)
      && $stable(o_opcode_fetch_status))
    else $error("status changed mid cycle");
  a_out_port_addr: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_output_cycle_status |-> o_addr[15:8] == o_addr[7:0])
    else $error("port address missing");

  a_strobe_data: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_write_strobe |-> o_bidir_data_lines_oe && o_output_cycle_status
      && $stable(o_bidir_data_lines_o))
    else $error("data not valid in strobe");
  a_data_latched: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_cycle_start |=> o_bidir_data_lines_o == $past(i_out_data))
    else $error("output data not latched");
  a_strobe_ready: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    s_strobe_rise |-> $past(ready_s) && o_output_cycle_status)
    else $error("strobe without ready");
  a_strobe_bound: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_write_strobe |-> hi_len_q < 8'(bus_status_pkg::WR_STROBE_CYC))
    else $error("strobe too long");

  // a strobe cut by the next cycle start is legal, so only full ones count
  a_strobe_width: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    s_strobe_fall ##0 !$past(i_cycle_start)
      |-> hi_len_q == 8'(bus_status_pkg::WR_STROBE_CYC))
    else $error("strobe too short");
endmodule // cpu_bus_status_outputs

// ==== test/backplane_board.sv ====
// model of an expansion board on the backplane: gives ready, takes out data.
// assumes strobe, data and enable come from the board under test on i_clk.
`timescale 1ns/1ps
module backplane_board (
  input wire logic i_clk,
  input wire logic i_stall,
  input wire logic i_write_strobe,
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  output logic o_ready,
  output logic [7:0] o_cap,
  output int o_hits
);
  // a slow board holds ready low, which must put the processor in wait
  int hit_count = 0;
  assign o_ready = !i_stall;
  assign o_hits = hit_count;
  // data only counts when it is really driven during the strobe
  always @(posedge i_clk) begin
    if (i_write_strobe && i_data_oe) begin
      o_cap <= i_data;
      hit_count <= hit_count + 1;
    end
  end
endmodule // backplane_board

// ==== test/cpu_bus_status_outputs_tb_top.sv ====
// self-checking bench for the backplane status outputs.
// assumes a 125 MHz clock and a board model that answers promptly or slowly.
`timescale 1ns/1ps
module cpu_bus_status_outputs_tb_top;
  logic clk = 0, rst_n = 0, cs = 0, ff = 0, oc = 0, hx = 0, ex = 0, dx = 0;
  logic rq = 0, stall = 0, ws, ie, acc, fs, os, oe, wr, rdy, acc_seen;
  logic [7:0] pa = 0, od = 0, dq, cap, p, d;
  logic [15:0] ma = 0, ad, m;
  logic f, o;
  int hits, h0, fail_count = 0, total_checks = 0, cyc = 0;
  int seed = 32'hfbb41701;
  initial forever #4 clk = ~clk;
  cpu_bus_status_outputs dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_cycle_start(cs), .i_fetch_first(ff), .i_out_cycle(oc),
    .i_port_addr(pa), .i_mem_addr(ma), .i_out_data(od), .i_halt_exec(hx),
    .i_ei_exec(ex), .i_di_exec(dx), .i_ready(rdy), .i_int_req(rq),
    .o_wait_state_out(ws), .o_int_enabled_out(ie), .o_int_accept(acc),
    .o_opcode_fetch_status(fs), .o_output_cycle_status(os), .o_addr(ad),
    .o_bidir_data_lines_o(dq), .o_bidir_data_lines_oe(oe),
    .o_write_strobe(wr));
  backplane_board board (.i_clk(clk), .i_stall(stall), .i_write_strobe(wr),
    .i_data(dq), .i_data_oe(oe), .o_ready(rdy), .o_cap(cap), .o_hits(hits));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one machine cycle start; acc_seen holds the pulse right after it
  task automatic mcycle;
    @(posedge clk);
    ff <= f;
    oc <= o;
    pa <= p;
    od <= d;
    ma <= m;
    cs <= 1;
    tick(1);
    cs <= 0;
    #1 acc_seen = acc;
  endtask
  function automatic logic [15:0] exp_addr(logic o, logic [7:0] p,
      logic [15:0] m);
    return o ? {p, p} : m;
  endfunction
  // hang guard; the whole run needs about 860 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    tick(20);
    rst_n <= 1;
    tick(6);
    #1 check(ws, 0);
    check(ie, 0);
    tick(1);
    stall <= 1;
    tick(4);
    #1 check(ws, 1);
    tick(1);
    stall <= 0;
    hx <= 1;
    tick(1);
    hx <= 0;
    ex <= 1;
    #1 check(ws, 1);
    tick(1);
    ex <= 0;
    rq <= 1;
    tick(4);
    #1 check(ie, 1);
    {f, o, p, d, m} = '0;
    mcycle();
    check(acc_seen, 1);
    tick(3);
    #1 check(ws, 0);
    tick(1);
    dx <= 1;
    tick(1);
    dx <= 0;
    tick(1);
    #1 check(ie, 0);
    mcycle();
    check(acc_seen, 0);
    for (int i = 0; i < 12; i++) begin
      {p, d, m} = $random(seed);
      f = (i == 1) | 1'($random(seed));
      o = (i == 0) | (!f & 1'($random(seed)));
      if (i == 0) {p, d} = 16'hff00;
      mcycle();
      h0 = hits;
      check(fs, f);
      check(os, o);
      check(ad, exp_addr(o, p, m));
      check(oe, o);
      tick(bus_status_pkg::WR_STROBE_CYC + 6);
      #1 check(16'(hits - h0),
        16'(o ? bus_status_pkg::WR_STROBE_CYC : 0));
      if (o) check(cap, d);
      check(fs, f);
      check(ad, exp_addr(o, p, m));
    end
    finish_test();
  end
endmodule // cpu_bus_status_outputs_tb_top
